// ===== lse_pkg.sv
/*
 * lane scrambler and 8b/10b encoder: shared constants and helpers.
 * assumes one core clock; included by every design file of the block.
 */
// Operation
// - scramble data by xor with lfsr bit
// - reload transmit generator seed each frame start
// - generator polynomial x16+x5+x4+x3+1
// - seed is all ones, ffff hex
// - every byte becomes one ten-bit character
// - never more than five equal bits run
// - characters carry five, six or four ones
// - running disparity follows character weight
// - positive disparity sends four-ones variant
// - only twelve control codes beyond data
// - low five bits through 5b/6b stage
// - six-bit subcodes weigh 3/4/2, d07 special
// - unbalanced subcodes complementary, chosen by disparity
// - k28 gets dedicated first-stage handling
// - 3b/4b stage yields high nibble, new disparity
// - only fourteen defined nibbles are emitted
// - nibble form chosen by subcode disparity
// - alternate dxx.7 nibbles for listed inputs
package lse_pkg;

	////////////////////////////////////////////////////////////////
	// generator
	localparam int          LSE_LFSR_W   = 16;
	localparam logic [15:0] LSE_SEED     = 16'hFFFF;
	localparam logic [15:0] LSE_TAPS     = 16'h0039; // x5, x4, x3, x0 feedback
	localparam int          LSE_BYTE_W   = 8;

	////////////////////////////////////////////////////////////////
	// coding fields
	localparam logic        LSE_RD_NEG   = 1'b0;
	localparam logic        LSE_RD_POS   = 1'b1;
	localparam logic [4:0]  LSE_X07      = 5'h07;
	localparam logic [4:0]  LSE_X11      = 5'h0B;
	localparam logic [4:0]  LSE_X13      = 5'h0D;
	localparam logic [4:0]  LSE_X14      = 5'h0E;
	localparam logic [4:0]  LSE_X17      = 5'h11;
	localparam logic [4:0]  LSE_X18      = 5'h12;
	localparam logic [4:0]  LSE_X20      = 5'h14;
	localparam logic [4:0]  LSE_X23      = 5'h17;
	localparam logic [4:0]  LSE_X27      = 5'h1B;
	localparam logic [4:0]  LSE_X28      = 5'h1C;
	localparam logic [4:0]  LSE_X29      = 5'h1D;
	localparam logic [4:0]  LSE_X30      = 5'h1E;
	localparam logic [2:0]  LSE_Y3       = 3'h3;
	localparam logic [2:0]  LSE_Y7       = 3'h7;
	localparam logic [5:0]  LSE_K28_NEG  = 6'b001111;
	localparam logic [3:0]  LSE_ALT7_NEG = 4'b0111;
	localparam int          LSE_HALF6    = 3;
	localparam int          LSE_HALF4    = 2;

	// count of ones in a sub-code
	function automatic int lse_ones(input logic [5:0] v);
		int n;
		n = 0;
		for (int i = 0; i < 6; i++) begin
			n = n + int'(v[i]);
		end
		return n;
	endfunction

endpackage

// ===== lse_lfsr_if.sv
/*
 * carrier between the encoder top and its scrambling generator.
 * assumes both ends share sys_clk.
 */
`timescale 1ns/1ps
interface lse_lfsr_if;
	import lse_pkg::*;

	logic                  restart; // reload seed this cycle
	logic                  advance; // consume one byte of sequence
	logic [LSE_BYTE_W-1:0] mask;    // sequence byte for this cycle

	modport gen (input restart, input advance, output mask);
	modport user (output restart, output advance, input mask);
endinterface

// ===== lse_lfsr.sv
/*
 * sixteen-stage pseudo-random generator, eight bits per byte.
 * assumes the user asserts restart on frame start and advance per data byte.
 */
`timescale 1ns/1ps
module lse_lfsr
	import lse_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic resetn,
	// user side
	lse_lfsr_if.gen   lf
);

	logic [LSE_LFSR_W-1:0] state;
	logic [LSE_LFSR_W-1:0] base;
	logic [LSE_LFSR_W-1:0] next_state;
	logic [LSE_BYTE_W-1:0] bits;

	////////////////////////////////////////////////////////////////
	// eight serial steps, msb out first each step
	always_comb begin
		logic [LSE_LFSR_W-1:0] s;
		s    = '0;
		base = lf.restart ? LSE_SEED : state;
		s    = base;
		bits = '0;
		for (int i = 0; i < LSE_BYTE_W; i++) begin
			bits[i] = s[LSE_LFSR_W-1];
			s = {s[LSE_LFSR_W-2:0], 1'b0} ^ (s[LSE_LFSR_W-1] ? LSE_TAPS : '0);
		end
		next_state = s;
	end

	assign lf.mask = bits;

	////////////////////////////////////////////////////////////////
	// state held at seed out of reset; restart alone parks at seed
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= LSE_SEED;
		end else if (lf.advance) begin
			state <= next_state;
		end else if (lf.restart) begin
			state <= LSE_SEED;
		end
	end

endmodule

// ===== lse_encoder.sv
/*
 * lane coding top: frame-synchronous scrambler then 8b/10b encoder.
 * assumes framing logic on sys_clk delivers one byte per valid cycle;
 * the serialiser takes every character the cycle it is presented.
 */
`timescale 1ns/1ps
module lse_encoder
	import lse_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// byte stream from framing
	input  wire logic       in_valid,
	input  wire logic [7:0] in_byte,
	input  wire logic       in_ctrl,
	input  wire logic       in_frame_start,
	input  wire logic       scramble_en,
	// character stream to serialiser
	output logic            out_valid,
	output logic [9:0]      out_char,
	output logic            out_rd,
	output logic            out_ctrl,
	output logic            out_frame_start,
	output logic            out_ctrl_err
);

	////////////////////////////////////////////////////////////////
	// 5b/6b table, form sent under negative running disparity
	function automatic logic [5:0] lse_sub6(input logic [4:0] x);
		logic [5:0] c;
		c = '0;
		case (x)
			5'h00: c = 6'b100111;
			5'h01: c = 6'b011101;
			5'h02: c = 6'b101101;
			5'h03: c = 6'b110001;
			5'h04: c = 6'b110101;
			5'h05: c = 6'b101001;
			5'h06: c = 6'b011001;
			5'h07: c = 6'b111000;
			5'h08: c = 6'b111001;
			5'h09: c = 6'b100101;
			5'h0A: c = 6'b010101;
			5'h0B: c = 6'b110100;
			5'h0C: c = 6'b001101;
			5'h0D: c = 6'b101100;
			5'h0E: c = 6'b011100;
			5'h0F: c = 6'b010111;
			5'h10: c = 6'b011011;
			5'h11: c = 6'b100011;
			5'h12: c = 6'b010011;
			5'h13: c = 6'b110010;
			5'h14: c = 6'b001011;
			5'h15: c = 6'b101010;
			5'h16: c = 6'b011010;
			5'h17: c = 6'b111010;
			5'h18: c = 6'b110011;
			5'h19: c = 6'b100110;
			5'h1A: c = 6'b010110;
			5'h1B: c = 6'b110110;
			5'h1C: c = 6'b001110;
			5'h1D: c = 6'b101110;
			5'h1E: c = 6'b011110;
			default: c = 6'b101011;
		endcase
		return c;
	endfunction

	////////////////////////////////////////////////////////////////
	// 3b/4b table, form sent after a negative sub-code disparity
	function automatic logic [3:0] lse_sub4(input logic [2:0] y, input logic k);
		logic [3:0] c;
		c = '0;
		case ({k, y})
			4'h0: c = 4'b1011;
			4'h1: c = 4'b1001;
			4'h2: c = 4'b0101;
			4'h3: c = 4'b1100;
			4'h4: c = 4'b1101;
			4'h5: c = 4'b1010;
			4'h6: c = 4'b0110;
			4'h7: c = 4'b1110;
			4'h8: c = 4'b1011;
			4'h9: c = 4'b0110;
			4'hA: c = 4'b1010;
			4'hB: c = 4'b1100;
			4'hC: c = 4'b1101;
			4'hD: c = 4'b0101;
			4'hE: c = 4'b1001;
			default: c = LSE_ALT7_NEG;
		endcase
		return c;
	endfunction

	////////////////////////////////////////////////////////////////
	// the twelve control characters the code space allows
	function automatic logic lse_k_ok(input logic [7:0] b);
		logic ok;
		ok = 1'b0;
		if (b[4:0] == LSE_X28) begin
			ok = 1'b1;
		end else if (b[7:5] == LSE_Y7) begin
			ok = (b[4:0] == LSE_X23) || (b[4:0] == LSE_X27) ||
			     (b[4:0] == LSE_X29) || (b[4:0] == LSE_X30);
		end
		return ok;
	endfunction

	lse_lfsr_if lf();

	logic       rd;
	logic [7:0] byte_s;
	logic [4:0] x5;
	logic [2:0] y3;
	logic       k_eff;
	logic [5:0] neg6;
	logic [5:0] code6;
	logic       unbal6;
	logic       rd6;
	logic [3:0] neg4;
	logic [3:0] code4;
	logic       unbal4;
	logic       alt7;
	logic       next_rd;
	logic       bad_k;

	////////////////////////////////////////////////////////////////
	// generator: reseeded on frame start, stepped per scrambled byte;
	// control characters pass clear so the receiver can find them
	assign lf.restart = in_valid && in_frame_start;
	assign lf.advance = in_valid && !in_ctrl && scramble_en;

	lse_lfsr u_lfsr (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.lf      (lf)
	);

	assign byte_s = lf.advance ? (in_byte ^ lf.mask) : in_byte;

	////////////////////////////////////////////////////////////////
	// an illegal control request is still sent, but coded as data, so
	// the line never carries a code outside the legal set
	assign bad_k = in_ctrl && !lse_k_ok(in_byte);
	assign k_eff = in_ctrl && !bad_k;
	assign x5    = byte_s[4:0];
	assign y3    = byte_s[7:5];

	////////////////////////////////////////////////////////////////
	// first stage: low five bits, flag and running disparity
	always_comb begin
		if (k_eff && (x5 == LSE_X28)) begin
			neg6 = LSE_K28_NEG;
		end else begin
			neg6 = lse_sub6(x5);
		end
		unbal6 = (lse_ones(neg6) != LSE_HALF6);
		// unbalanced pairs and d07 flip with positive disparity
		if ((unbal6 || (x5 == LSE_X07)) && (rd == LSE_RD_POS)) begin
			code6 = ~neg6;
		end else begin
			code6 = neg6;
		end
		rd6 = unbal6 ? ~rd : rd;
	end

	////////////////////////////////////////////////////////////////
	// second stage: high three bits against sub-code disparity
	always_comb begin
		alt7 = 1'b0;
		if (!k_eff && (y3 == LSE_Y7)) begin
			if (rd6 == LSE_RD_NEG) begin
				alt7 = (x5 == LSE_X17) || (x5 == LSE_X18) || (x5 == LSE_X20);
			end else begin
				alt7 = (x5 == LSE_X11) || (x5 == LSE_X13) || (x5 == LSE_X14);
			end
		end
		// alternate form breaks the run of five across the boundary
		neg4   = alt7 ? LSE_ALT7_NEG : lse_sub4(y3, k_eff);
		unbal4 = (lse_ones({2'b00, neg4}) != LSE_HALF4);
		// balanced x.3 and balanced control nibbles also flip
		if ((unbal4 || k_eff || (y3 == LSE_Y3)) && (rd6 == LSE_RD_POS)) begin
			code4 = ~neg4;
		end else begin
			code4 = neg4;
		end
		next_rd = unbal4 ? ~rd6 : rd6;
	end

	////////////////////////////////////////////////////////////////
	// running disparity, negative out of reset
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rd <= LSE_RD_NEG;
		end else if (in_valid) begin
			rd <= next_rd;
		end
	end

	////////////////////////////////////////////////////////////////
	// registered character stream, one byte in gives one character out
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			out_valid       <= 1'b0;
			out_char        <= '0;
			out_rd          <= LSE_RD_NEG;
			out_ctrl        <= 1'b0;
			out_frame_start <= 1'b0;
			out_ctrl_err    <= 1'b0;
		end else begin
			out_valid       <= in_valid;
			out_frame_start <= in_valid && in_frame_start;
			out_ctrl_err    <= in_valid && bad_k;
			if (in_valid) begin
				out_char <= {code4, code6};
				out_rd   <= next_rd;
				out_ctrl <= k_eff;
			end
		end
	end

endmodule

// ===== lse_props.sv
/*
 * timing and coding checks on the lane coder's ports.
 * assumes one clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module lse_props (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       resetn,
	// byte side
	input wire logic       in_valid,
	input wire logic       in_ctrl,
	input wire logic       in_frame_start,
	// character side
	input wire logic       out_valid,
	input wire logic [9:0] out_char,
	input wire logic       out_rd,
	input wire logic       out_ctrl,
	input wire logic       out_frame_start,
	input wire logic       out_ctrl_err
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////
	// latency, framing, character kind and reset state
	chk_answer_one: assert property (in_valid |=> out_valid)
		else $error("no character one cycle after a byte");
	chk_no_extra: assert property (!in_valid |=> !out_valid && !out_frame_start)
		else $error("character without a byte");
	chk_frame_mark: assert property (in_valid && in_frame_start |=> out_frame_start)
		else $error("frame start not marked");
	chk_ctrl_kind: assert property (in_valid && in_ctrl |=> out_ctrl != out_ctrl_err)
		else $error("control request neither sent nor flagged");
	chk_data_kind: assert property (in_valid && !in_ctrl |=> !out_ctrl && !out_ctrl_err)
		else $error("data byte sent as control");
	chk_reset_state: assert property ($rose(resetn) |-> !out_rd && !out_valid)
		else $error("disparity not negative after reset");

	////////////////////////////////////////////////////////////////
	// code weights and running disparity
	chk_char_weight: assert property (out_valid |-> $countones(out_char) inside {4, 5, 6})
		else $error("character weight out of range");
	chk_sub_weight: assert property (out_valid |-> $countones(out_char[5:0]) inside {2, 3, 4})
		else $error("sub-code weight out of range");
	chk_nibble_set: assert property (out_valid |-> !(out_char[9:6] inside {4'h0, 4'hF}))
		else $error("undefined nibble emitted");
	chk_rd_flip: assert property (out_valid && $countones(out_char) != 5
		|-> out_rd == !$past(out_rd) && out_rd == ($countones(out_char) == 6))
		else $error("unbalanced character with wrong disparity");
	chk_rd_balanced: assert property (out_valid && $countones(out_char) == 5 |-> $stable(out_rd))
		else $error("balanced character moved disparity");

	// main scenarios
	cover property (in_valid && in_ctrl ##1 out_ctrl);
	cover property (out_valid && out_char[9:6] == 4'h7);
	cover property (out_ctrl_err);
	cover property (out_frame_start);
endmodule

bind lse_encoder lse_props u_props (.sys_clk, .resetn, .in_valid, .in_ctrl, .in_frame_start,
	.out_valid, .out_char, .out_rd, .out_ctrl, .out_frame_start, .out_ctrl_err);

// ===== lse_rx_model.sv
/*
 * far end: serialiser and receiver checking runs, weights and disparity.
 * assumes characters sampled on sys_clk while valid is high.
 */
`timescale 1ns/1ps
module lse_rx_model (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// characters in
	input  wire logic       valid,
	input  wire logic [9:0] chr,
	// faults seen, kept across resets
	output int              n_bad
);
	logic rd = 1'b0;
	logic bit_now;
	logic last = 1'b0;
	int   run = 0;
	int   cnt = 0;
	int   w;

	assign n_bad = cnt;

	////////////////////////////////////////////////////////////////
	// serial order a..i then f..j; the run carries across characters
	always @(posedge sys_clk) begin
		if (!resetn) begin
			rd = 1'b0;
			run = 0;
		end else if (valid) begin
			for (int k = 0; k < 10; k++) begin
				bit_now = (k < 6) ? chr[5-k] : chr[15-k];
				run = (run > 0 && bit_now == last) ? run + 1 : 1;
				last = bit_now;
				if (run > 5) cnt++;
			end
			w = $countones(chr);
			if (w < 4 || w > 6) cnt++;
			if ((w == 6 && rd) || (w == 4 && !rd)) cnt++;
			if (w != 5) rd = (w == 6);
		end
	end
endmodule

// ===== lane_scrambler_8b10b_encoder_tb_top.sv
/*
 * self-checking bench for the lane coder.
 * assumes one answer exactly one cycle after each taken byte.
 */
`timescale 1ns/1ps
module lane_scrambler_8b10b_encoder_tb_top;
	import lse_pkg::*;
	logic       sys_clk = 1'b0;
	logic       resetn = 1'b0;
	logic       in_valid = 1'b0, in_ctrl = 1'b0, in_frame_start = 1'b0, scramble_en = 1'b0;
	logic [7:0] in_byte = 8'h00;
	logic       out_valid, out_rd, out_ctrl, out_frame_start, out_ctrl_err;
	logic [9:0] out_char;
	logic       o_valid, o_rd, o_ctrl, o_fs, o_err;
	logic [9:0] o_char;
	logic [9:0] got [0:2];
	int         n_errors = 0;
	int         tests_run = 0;
	int         n_bad;
	// K28.5 D0.0 D7.0 D7.0 D11.7 D17.7 K28.0 K23.7 from negative disparity
	localparam logic [7:0]  TB_BYTE [8] = '{8'hBC, 8'h00, 8'h07, 8'h07, 8'hEB, 8'hF1, 8'h1C,
		8'hF7};
	localparam logic [7:0]  TB_K = 8'hC1;
	localparam logic [10:0] TB_EXP [8] = '{11'h68F, 11'h6D8, 11'h107, 11'h6F8, 11'h234,
		11'h5E3, 11'h6F0, 11'h5C5};

	always #10 sys_clk = ~sys_clk;

	lse_encoder dut (.sys_clk, .resetn, .in_valid, .in_byte, .in_ctrl, .in_frame_start,
		.scramble_en, .out_valid, .out_char, .out_rd, .out_ctrl, .out_frame_start, .out_ctrl_err);
	lse_rx_model far (.sys_clk, .resetn, .valid(out_valid), .chr(out_char), .n_bad);

	////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic report_and_stop;
		if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] seen);
		tests_run++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
			n_errors++;
		end
	endtask

	// falling edge: take the last answer, then present the next byte
	task automatic cyc(input logic v, input logic [7:0] b, input logic k, fs, scr);
		@(negedge sys_clk);
		{o_valid, o_char, o_rd, o_ctrl, o_fs, o_err} =
			{out_valid, out_char, out_rd, out_ctrl, out_frame_start, out_ctrl_err};
		{in_valid, in_byte, in_ctrl, in_frame_start, scramble_en} = {v, b, k, fs, scr};
	endtask

	task automatic do_reset;
		resetn = 1'b0;
		repeat (3) cyc(1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
		resetn = 1'b1;
	endtask

	// generator steps from the rule polynomial, bit 15 leaves first into mask bit 0
	function automatic logic [7:0] mask_byte(inout logic [15:0] st);
		logic [7:0] m;
		for (int i = 0; i < 8; i++) begin
			m[i] = st[15];
			st = {st[14:0], 1'b0} ^ (st[15] ? 16'h0039 : 16'h0000);
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset_state;
		do_reset;
		cyc(1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
		chk("reset flags", 11'h000, {9'h000, o_valid, o_rd});
	endtask

	// back to back, covers both alternates and both D7 forms
	task automatic t_code_table;
		do_reset;
		for (int i = 0; i <= 8; i++) begin
			if (i < 8) cyc(1'b1, TB_BYTE[i], TB_K[i], i == 0, 1'b0);
			else cyc(1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
			if (i > 0) begin
				chk("rd and char", TB_EXP[i-1], {o_rd, o_char});
				chk("kind", {9'h000, TB_K[i-1], o_valid}, {9'h000, o_ctrl, 1'b1});
				chk("frame mark", {10'h000, i == 1}, {10'h000, o_fs});
			end
		end
	endtask

	task automatic t_illegal_k;
		do_reset;
		cyc(1'b1, 8'h00, 1'b1, 1'b0, 1'b0);
		cyc(1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
		chk("illegal control", 11'h001, {9'h000, o_ctrl, o_err});
	endtask

	task automatic run3(input logic scr, input logic [7:0] b0, b1);
		do_reset;
		cyc(1'b1, b0, 1'b0, 1'b1, scr);
		cyc(1'b1, b1, 1'b0, 1'b0, scr);
		got[0] = o_char;
		cyc(1'b1, b0, 1'b0, 1'b1, scr);
		got[1] = o_char;
		cyc(1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
		got[2] = o_char;
	endtask

	// scrambled zeros must code like the plain sequence, reseeded per frame
	task automatic t_scramble;
		logic [9:0]  plain [0:2];
		logic [15:0] st;
		logic [7:0]  m0, m1;
		st = 16'hFFFF;
		m0 = mask_byte(st);
		m1 = mask_byte(st);
		run3(1'b0, m0, m1);
		plain = got;
		run3(1'b1, 8'h00, 8'h00);
		for (int j = 0; j < 3; j++) begin
			chk("scrambled char", {1'b0, plain[j]}, {1'b0, got[j]});
		end
	endtask

	// control frame start goes clear and parks the generator at seed
	task automatic t_ctrl_seed;
		logic [15:0] st;
		logic [7:0]  m0;
		logic [9:0]  plain;
		st = 16'hFFFF;
		m0 = mask_byte(st);
		do_reset;
		cyc(1'b1, 8'hBC, 1'b1, 1'b1, 1'b0);
		cyc(1'b1, m0, 1'b0, 1'b0, 1'b0);
		cyc(1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
		plain = o_char;
		do_reset;
		cyc(1'b1, 8'hBC, 1'b1, 1'b1, 1'b1);
		cyc(1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
		chk("clear control", 11'h68F, {o_rd, o_char});
		cyc(1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
		chk("first data after control", {1'b0, plain}, {1'b0, o_char});
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence and hang guard
	initial begin
		t_reset_state;
		t_code_table;
		t_illegal_k;
		t_scramble;
		t_ctrl_seed;
		chk("far end faults", 11'h000, n_bad[10:0]);
		report_and_stop;
	end

	initial begin
		repeat (2000) @(posedge sys_clk);
		n_errors++;
		report_and_stop;
	end
endmodule
